// ---- design/plhc_pkg.sv ----
// package of constants for the loop lock and backup clock control block
// assumes a single 40 MHz control clock and a plain register port
package plhc_pkg;
  // register addresses
  localparam logic [3:0] ADDR_SYNTH = 4'h0;
  localparam logic [3:0] ADDR_DIVIDE = 4'h1;
  localparam logic [3:0] ADDR_MULT = 4'h2;
  localparam logic [3:0] ADDR_WATCH = 4'h3;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_MEASURE = 4'h5;
  // control register fields
  localparam int BIT_POWER = 0;
  localparam int BIT_AUTO = 1;
  localparam int BIT_ACQ = 2;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_BUS_SYNTH = 4;
  localparam int BIT_MODULE_SEL = 5;
  // monitor register fields
  localparam int BIT_WATCH = 0;
  localparam int BIT_FORCED_WATCH = 1;
  localparam int BIT_INHIBIT = 2;
  // flag register fields
  localparam int BIT_LOCKED = 0;
  localparam int BIT_LOCK_IRQ = 1;
  localparam int BIT_BACKUP = 2;
  localparam int BIT_BACKUP_IRQ = 3;
  localparam int BIT_STOP_LATCH = 4;
  // reset values
  localparam logic [7:0] RESET_SYNTH = 8'h03;
  localparam logic [2:0] RESET_DIVIDE = 3'h0;
  localparam logic [5:0] RESET_MULT = 6'h00;
  localparam logic [2:0] RESET_WATCH = 3'h1;
  // timing
  localparam int SLOW_POLL_COUNT = 8192;
  localparam int SLOW_POLL_MID = 4096;
  localparam int WINDOW_CYCLES = 256;
  localparam int CLOCK_MHZ = 40;
  localparam int MISS_TIME_NS = 2000;
  localparam int MISS_CYCLES = (MISS_TIME_NS * CLOCK_MHZ) / 1000;
endpackage

// ---- design/plhc_top.sv ----
// loop lock detection, filter mode and backup clock control
// assumes crystal, feedback and slow clocks as async pins, sampled here
`timescale 1ns/100ps
`default_nettype none
module plhc_top #(
  parameter int LOCK_IN = 2,
  parameter int LOCK_OUT = 4,
  parameter int TRACK_IN = 4,
  parameter int TRACK_OUT = 8,
  parameter int POLL_COUNT = plhc_pkg::SLOW_POLL_COUNT,
  parameter int POLL_MID = plhc_pkg::SLOW_POLL_MID
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // asynchronous clock pins
  input wire logic i_crystal_input_clock,
  input wire logic i_vco_feedback_clock,
  input wire logic i_slow_module_clock,
  // device state
  input wire logic i_synth_supply,
  input wire logic i_stop_mode,
  input wire logic i_normal_mode,
  input wire logic i_power_on,
  // analog and clock tree controls
  output logic o_reference_clock,
  output logic [5:0] o_multiplier,
  output logic o_synth_power_on,
  output logic o_filter_track,
  output logic o_bypass,
  output logic o_bus_source_synth_select,
  output logic o_module_source_select,
  output logic o_vco_floor_frequency,
  output logic o_monitor_reset,
  output logic o_lock_irq,
  output logic o_backup_irq
);
  import plhc_pkg::*;

  logic [7:0] synth_ctl;
  logic [2:0] divide;
  logic [5:0] mult;
  logic [2:0] watch;
  logic locked, lock_irq, backup, backup_irq, stop_latch, acq_auto;
  logic [2:0] xs, fs, ss;
  logic [1:0] sup_s, stop_s, norm_s;
  logic [2:0] div_cnt;
  logic ref_clk;
  logic [13:0] ref_cnt, fb_cnt;
  logic [15:0] win_cnt;
  logic [13:0] meas;
  logic meas_done;
  logic [7:0] miss_cnt;
  logic crystal_lost;
  logic [12:0] slow_cnt;
  logic poll;
  logic saved_bus, saved_mod;
  logic watch_on;
  logic [13:0] err;
  logic [13:0] expect_cnt;

  // pin synchronisers
  always_ff @(posedge i_mclk) begin
    xs <= {xs[1:0], i_crystal_input_clock};
    fs <= {fs[1:0], i_vco_feedback_clock};
    ss <= {ss[1:0], i_slow_module_clock};
    sup_s <= {sup_s[0], i_synth_supply};
    stop_s <= {stop_s[0], i_stop_mode};
    norm_s <= {norm_s[0], i_normal_mode};
  end

  // reference divider, one to eight
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      div_cnt <= 3'h0;
      ref_clk <= 1'b0;
    end else if (xs[2] & ~xs[1]) begin
      if (div_cnt == divide) begin
        div_cnt <= 3'h0;
        ref_clk <= ~ref_clk;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end

  // lock detector: count feedback edges over a reference window
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ref_cnt <= 14'h0;
      fb_cnt <= 14'h0;
      win_cnt <= 16'h0;
      meas <= 14'h0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (xs[2] & ~xs[1]) begin
        win_cnt <= win_cnt + 16'h1;
      end
      if (fs[2] & ~fs[1]) begin
        fb_cnt <= fb_cnt + 14'h1;
      end
      if (win_cnt == 16'(WINDOW_CYCLES)) begin
        win_cnt <= 16'h0;
        meas <= fb_cnt;
        fb_cnt <= 14'h0;
        meas_done <= 1'b1;
      end
      ref_cnt <= 14'h0;
    end
  end

  // expected feedback count: window / divisor * multiplier
  always_comb begin
    expect_cnt = 14'((WINDOW_CYCLES / (32'(divide) + 1)) * (32'(mult) + 1));
    err = (meas > expect_cnt) ? meas - expect_cnt : expect_cnt - meas;
  end

  // lock and track state with hysteresis windows
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      locked <= 1'b0;
      acq_auto <= 1'b0;
    end else if (!synth_ctl[BIT_POWER] || stop_s[1]) begin
      locked <= 1'b0;
      acq_auto <= 1'b0;
    end else if (meas_done) begin
      if (err <= 14'(LOCK_IN)) begin
        locked <= 1'b1;
      end else if (err > 14'(LOCK_OUT)) begin
        locked <= 1'b0;
      end
      if (err <= 14'(TRACK_IN)) begin
        acq_auto <= 1'b1;
      end else if (err > 14'(TRACK_OUT)) begin
        acq_auto <= 1'b0;
      end
    end
  end

  assign watch_on = watch[BIT_WATCH] | watch[BIT_FORCED_WATCH] | backup;

  // crystal loss monitor
  always_ff @(posedge i_mclk) begin
    // keeps watching through device reset so reset can fall back
    if (i_power_on) begin
      miss_cnt <= 8'h0;
      crystal_lost <= 1'b0;
    end else if (xs[2] ^ xs[1]) begin
      miss_cnt <= 8'h0;
      crystal_lost <= 1'b0;
    end else if (miss_cnt == 8'(MISS_CYCLES)) begin
      crystal_lost <= watch_on;
    end else begin
      miss_cnt <= miss_cnt + 8'h1;
    end
  end

  // 13-stage slow counter, poll at mid count
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      slow_cnt <= 13'h0;
      poll <= 1'b0;
    end else begin
      poll <= 1'b0;
      if (ss[2] & ~ss[1]) begin
        slow_cnt <= (slow_cnt == 13'(POLL_COUNT - 1)) ? 13'h0 : slow_cnt + 13'h1;
        poll <= (slow_cnt == 13'(POLL_MID - 1));
      end
    end
  end

  // reset latch after monitor reset, survives the device reset
  always_ff @(posedge i_mclk) begin
    if (i_power_on) begin
      stop_latch <= 1'b0;
      o_monitor_reset <= 1'b0;
    end else if (crystal_lost && watch[BIT_INHIBIT] && !backup) begin
      stop_latch <= 1'b1;
      o_monitor_reset <= 1'b1;
    end else if (stop_latch && (xs[2] ^ xs[1])) begin
      o_monitor_reset <= 1'b0;
    end else if (!i_reset && !o_monitor_reset) begin
      stop_latch <= 1'b0;
    end
  end

  // backup mode entry and exit
  always_ff @(posedge i_mclk) begin
    if (i_reset && !stop_latch && crystal_lost && sup_s[1] && norm_s[1]) begin
      backup <= 1'b1;
    end else if (i_reset) begin
      backup <= 1'b0;
    end else if (!backup && crystal_lost && sup_s[1] && !watch[BIT_INHIBIT]
                 && !stop_latch) begin
      backup <= 1'b1;
    end else if (backup && poll && !crystal_lost) begin
      backup <= 1'b0;
    end
  end

  // saved selections, restored on exit
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      saved_bus <= 1'b0;
      saved_mod <= 1'b0;
    end else if (!backup) begin
      saved_bus <= synth_ctl[BIT_BUS_SYNTH];
      saved_mod <= synth_ctl[BIT_MODULE_SEL];
    end
  end

  // control registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      synth_ctl <= RESET_SYNTH;
      divide <= RESET_DIVIDE;
      mult <= RESET_MULT;
      watch <= RESET_WATCH;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_SYNTH: begin
          synth_ctl[BIT_POWER] <= i_wdata[BIT_POWER] | backup;
          synth_ctl[BIT_AUTO] <= i_wdata[BIT_AUTO];
          if (!synth_ctl[BIT_AUTO]) begin
            synth_ctl[BIT_ACQ] <= i_wdata[BIT_ACQ];
          end
          synth_ctl[BIT_IRQ_EN] <= i_wdata[BIT_IRQ_EN];
          synth_ctl[BIT_BUS_SYNTH] <= i_wdata[BIT_BUS_SYNTH];
          synth_ctl[BIT_MODULE_SEL] <= i_wdata[BIT_MODULE_SEL];
        end
        ADDR_DIVIDE: divide <= i_wdata[2:0];
        ADDR_MULT: mult <= i_wdata[5:0];
        ADDR_WATCH: watch <= i_wdata[2:0];
        default: ;
      endcase
    end else if (backup) begin
      synth_ctl[BIT_POWER] <= 1'b1;
    end
  end

  // sticky interrupt flags, set wins over clear
  logic lock_prev, backup_prev;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lock_prev <= 1'b0;
      backup_prev <= 1'b0;
      lock_irq <= 1'b0;
      backup_irq <= 1'b0;
    end else begin
      lock_prev <= locked;
      backup_prev <= backup;
      if (locked != lock_prev) begin
        lock_irq <= 1'b1;
      end else if (i_wr && i_addr == ADDR_FLAGS && i_wdata[BIT_LOCK_IRQ]) begin
        lock_irq <= 1'b0;
      end
      if (backup != backup_prev) begin
        backup_irq <= 1'b1;
      end else if (i_wr && i_addr == ADDR_FLAGS && i_wdata[BIT_BACKUP_IRQ]) begin
        backup_irq <= 1'b0;
      end
    end
  end

  // outputs to analog and clock tree
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_reference_clock <= 1'b0;
      o_multiplier <= RESET_MULT;
      o_synth_power_on <= 1'b0;
      o_filter_track <= 1'b0;
      o_bypass <= 1'b1;
      o_bus_source_synth_select <= 1'b0;
      o_module_source_select <= 1'b0;
      o_vco_floor_frequency <= 1'b0;
      o_lock_irq <= 1'b0;
      o_backup_irq <= 1'b0;
    end else begin
      o_reference_clock <= ref_clk;
      o_multiplier <= mult;
      // power stays on through wait; stop and low supply halt it
      o_synth_power_on <= sup_s[1] && !stop_s[1]
                          && (synth_ctl[BIT_POWER] || backup);
      o_filter_track <= synth_ctl[BIT_AUTO] ? acq_auto : synth_ctl[BIT_ACQ];
      o_bypass <= !sup_s[1];
      o_bus_source_synth_select <= sup_s[1]
                                   && (backup || saved_bus);
      o_module_source_select <= !backup && saved_mod;
      o_vco_floor_frequency <= backup;
      o_lock_irq <= lock_irq && synth_ctl[BIT_IRQ_EN];
      o_backup_irq <= backup_irq;
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_SYNTH: o_rdata <= {synth_ctl[7:3],
                                synth_ctl[BIT_AUTO] ? acq_auto : synth_ctl[BIT_ACQ],
                                synth_ctl[1:0]};
        ADDR_DIVIDE: o_rdata <= {5'h00, divide};
        ADDR_MULT: o_rdata <= {2'h0, mult};
        ADDR_WATCH: o_rdata <= {5'h00, watch};
        ADDR_FLAGS: o_rdata <= {3'h0, stop_latch, backup_irq, backup, lock_irq, locked};
        ADDR_MEASURE: o_rdata <= meas[7:0];
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- tb/plhc_analog_model.sv ----
// crystal, feedback and slow clock model of the analog side
// assumes the bench steers crystal run and detune
`timescale 1ns/100ps
`default_nettype none
module plhc_analog_model (
  // controls
  input wire logic i_run,
  input wire logic i_power,
  input wire logic i_detune,
  // clocks
  output var logic o_crystal,
  output var logic o_feedback,
  output var logic o_slow
);
  initial begin
    o_crystal = 1'b0;
    forever begin
      #100;
      if (i_run) o_crystal = ~o_crystal;
    end
  end
  initial begin
    o_feedback = 1'b0;
    forever begin
      #(i_detune ? 150 : 100);
      if (i_power) o_feedback = ~o_feedback;
    end
  end
  initial begin
    o_slow = 1'b0;
    forever #400 o_slow = ~o_slow;
  end
endmodule
`default_nettype wire

// ---- tb/plhc_top_properties.sv ----
// port checker for the loop lock and backup clock block
// assumes binding onto plhc_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module plhc_top_properties (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pins
  input wire logic i_synth_supply,
  input wire logic [5:0] o_multiplier,
  input wire logic o_synth_power_on,
  input wire logic o_filter_track,
  input wire logic o_bypass,
  input wire logic o_bus_source_synth_select,
  input wire logic o_module_source_select,
  input wire logic o_vco_floor_frequency,
  input wire logic o_lock_irq,
  input wire logic o_backup_irq
);
  import plhc_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic lock_clear;
  assign lock_clear = i_wr && ((i_addr == ADDR_FLAGS && i_wdata[BIT_LOCK_IRQ])
                               || i_addr == ADDR_SYNTH);
  sequence s_mult_write;
    i_wr && i_addr == ADDR_MULT;
  endsequence
  sequence s_manual_write;
    i_wr && i_addr == ADDR_SYNTH && !i_wdata[BIT_AUTO];
  endsequence
  sequence s_floor_held;
    o_vco_floor_frequency ##1 o_vco_floor_frequency;
  endsequence
  sequence s_bypass_held;
    o_bypass ##1 o_bypass;
  endsequence
  a_mult_follows: assert property (
    s_mult_write |-> ##2 o_multiplier == $past(i_wdata[5:0], 2))
    else $error("multiplier not updated");
  a_manual_track: assert property (
    s_manual_write |-> ##2 o_filter_track == $past(i_wdata[BIT_ACQ], 2))
    else $error("manual filter mode wrong");
  a_lock_irq_held: assert property (
    o_lock_irq && !lock_clear && !$past(lock_clear) |=> o_lock_irq)
    else $error("lock request dropped");
  a_read_idle: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read");
  a_bypass_supply: assert property (
    $fell(i_synth_supply) |-> ##[1:3] o_bypass)
    else $error("no bypass on low supply");
  a_bypass_power: assert property (
    s_bypass_held |-> !o_synth_power_on)
    else $error("loop powered in bypass");
  a_backup_forces: assert property (
    s_floor_held |-> o_synth_power_on && o_bus_source_synth_select && !o_module_source_select)
    else $error("backup selections not forced");
  a_backup_entry_irq: assert property (
    $rose(o_vco_floor_frequency) |-> ##[0:2] o_backup_irq)
    else $error("no backup flag on entry");
  a_backup_exit_irq: assert property (
    $fell(o_vco_floor_frequency) |-> ##[0:2] o_backup_irq)
    else $error("no backup flag on exit");
endmodule
bind plhc_top plhc_top_properties i_plhc_top_properties (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_synth_supply(i_synth_supply),
  .o_multiplier(o_multiplier), .o_synth_power_on(o_synth_power_on),
  .o_filter_track(o_filter_track), .o_bypass(o_bypass),
  .o_bus_source_synth_select(o_bus_source_synth_select),
  .o_module_source_select(o_module_source_select),
  .o_vco_floor_frequency(o_vco_floor_frequency), .o_lock_irq(o_lock_irq),
  .o_backup_irq(o_backup_irq)
);
`default_nettype wire

// ---- tb/plhc_top_bench.sv ----
// self-checking bench for the loop lock and backup clock block
// assumes a shortened slow poll and the analog model alongside
`timescale 1ns/100ps
`default_nettype none
module plhc_top_bench;
  import plhc_pkg::*;
  logic i_mclk;
  logic reset = 1'b1, pwr_on = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic supply = 1'b1, run = 1'b1, detune = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rd_val, d, m;
  logic [7:0] shadow [6];
  logic [5:0] mult;
  logic xtal, fb, slow, pwr, trk, byp, bus_sel, mod_sel, vco_floor, mon_rst, lock_irq, bk_irq;
  logic ref_out, prev_ref;
  int err_count = 0, n_compared = 0, n_tog = 0;
  plhc_top #(.POLL_COUNT(16), .POLL_MID(8)) i_plhc_top (
    .i_mclk(i_mclk), .i_reset(reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_crystal_input_clock(xtal), .i_vco_feedback_clock(fb),
    .i_slow_module_clock(slow), .i_synth_supply(supply), .i_stop_mode(1'b0),
    .i_normal_mode(1'b1), .i_power_on(pwr_on), .o_reference_clock(ref_out),
    .o_multiplier(mult),
    .o_synth_power_on(pwr), .o_filter_track(trk), .o_bypass(byp),
    .o_bus_source_synth_select(bus_sel), .o_module_source_select(mod_sel),
    .o_vco_floor_frequency(vco_floor), .o_monitor_reset(mon_rst), .o_lock_irq(lock_irq),
    .o_backup_irq(bk_irq));
  plhc_analog_model i_plhc_analog_model (.i_run(run), .i_power(pwr), .i_detune(detune),
    .o_crystal(xtal), .o_feedback(fb), .o_slow(slow));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge i_mclk);
    wr_s <= 1'b0;
    shadow[a] = v;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge i_mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_mclk);
    rd_s <= 1'b0;
    @(negedge i_mclk);
    rd_val = rdata;
    check(rd_val & mask, exp);
  endtask
  task automatic wait_out(input int sel, input logic val);
    logic v;
    for (int n = 0; n < 20000; n++) begin
      @(negedge i_mclk);
      v = sel == 0 ? lock_irq : sel == 1 ? vco_floor : mon_rst;
      if (v === val) return;
    end
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask
  initial begin
    void'($urandom(32'h37e07293));
    repeat (20) @(posedge i_mclk);
    reset <= 1'b0;
    pwr_on <= 1'b0;
    rdchk(ADDR_SYNTH, 8'hff, RESET_SYNTH);
    rdchk(ADDR_WATCH, 8'hff, {5'h00, RESET_WATCH});
    rdchk(4'hf, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom_range(7, 0));
      m = 8'($urandom_range(63, 0));
      wr(ADDR_DIVIDE, d);
      wr(ADDR_MULT, m);
      rdchk(ADDR_DIVIDE, 8'hff, shadow[ADDR_DIVIDE]);
      rdchk(ADDR_MULT, 8'hff, shadow[ADDR_MULT]);
      check({2'b00, mult}, m);
    end
    wr(ADDR_DIVIDE, 8'h01);
    prev_ref = ref_out;
    repeat (800) begin
      @(negedge i_mclk);
      if (ref_out !== prev_ref) n_tog++;
      prev_ref = ref_out;
    end
    check({7'h00, n_tog >= 44 && n_tog <= 52}, 8'h01);
    wr(ADDR_DIVIDE, 8'h00);
    wr(ADDR_MULT, 8'h00);
    // automatic mode lock, then detune
    wr(ADDR_SYNTH, 8'h0b);
    wait_out(0, 1'b1);
    rdchk(ADDR_FLAGS, 8'h03, 8'h03);
    rdchk(ADDR_SYNTH, 8'h04, 8'h04);
    check({7'h00, trk}, 8'h01);
    wr(ADDR_FLAGS, 8'h02);
    rdchk(ADDR_FLAGS, 8'h02, 8'h00);
    detune <= 1'b1;
    wait_out(0, 1'b1);
    rdchk(ADDR_FLAGS, 8'h01, 8'h00);
    wr(ADDR_FLAGS, 8'h02);
    detune <= 1'b0;
    // manual mode
    wr(ADDR_SYNTH, 8'h08);
    wr(ADDR_SYNTH, 8'h09);
    repeat (3) @(negedge i_mclk);
    check({7'h00, trk}, 8'h00);
    wait_out(0, 1'b1);
    wr(ADDR_SYNTH, 8'h0d);
    repeat (3) @(negedge i_mclk);
    check({7'h00, trk}, 8'h01);
    wr(ADDR_SYNTH, 8'h3d);
    repeat (3) @(negedge i_mclk);
    check({6'h00, bus_sel, mod_sel}, 8'h03);
    // crystal loss with backup allowed
    wr(ADDR_FLAGS, 8'h0a);
    run <= 1'b0;
    wait_out(1, 1'b1);
    check({5'h00, pwr, bus_sel, mod_sel}, 8'h06);
    rdchk(ADDR_FLAGS, 8'h0c, 8'h0c);
    wr(ADDR_FLAGS, 8'h08);
    run <= 1'b1;
    wait_out(1, 1'b0);
    rdchk(ADDR_FLAGS, 8'h0c, 8'h08);
    check({7'h00, mod_sel}, 8'h01);
    // crystal loss with backup inhibited
    wr(ADDR_WATCH, 8'h05);
    run <= 1'b0;
    wait_out(2, 1'b1);
    check({7'h00, vco_floor}, 8'h00);
    @(posedge i_mclk);
    reset <= 1'b1;
    repeat (20) @(posedge i_mclk);
    reset <= 1'b0;
    rdchk(ADDR_WATCH, 8'hff, 8'h01);
    repeat (200) @(negedge i_mclk);
    check({6'h00, vco_floor, mon_rst}, 8'h01);
    run <= 1'b1;
    wait_out(2, 1'b0);
    repeat (3) @(negedge i_mclk);
    rdchk(ADDR_FLAGS, 8'h10, 8'h00);
    check({7'h00, mon_rst}, 8'h00);
    supply <= 1'b0;
    repeat (4) @(negedge i_mclk);
    check({6'h00, byp, pwr}, 8'h02);
    finish_test();
  end
endmodule
`default_nettype wire
